// ==== clock_select_defines.vh ====
// register map, field positions, reset values and counts of the clock selector
`ifndef CLOCK_SELECT_DEFINES_VH
`define CLOCK_SELECT_DEFINES_VH

// register byte offsets
`define MODE_CTRL_OFFSET        12'h000
`define TIME_BASE_CTRL_OFFSET   12'h004
`define SYS_CTRL_OFFSET         12'h008
`define CLOCK_STATUS_OFFSET     12'h00c

// mode control fields
`define MODE_DIV_SEL_HI         7
`define MODE_DIV_SEL_LO         5
`define MODE_FAST_WAKE_BIT      4
`define MODE_SLOW_READY_BIT     3
`define MODE_FAST_READY_BIT     2
`define MODE_IDLE_ENABLE_BIT    1
`define MODE_FAST_SELECT_BIT    0
`define MODE_CTRL_RESET         8'h03

// time base control and system control fields
`define TBC_SLOW_LOW_POWER_BIT  0
`define TBC_RESET               8'h00
`define SYS_SYSTEM_CLOCK_OUT_ON_BIT         0
`define SYS_CTRL_RESET          8'h00

// status fields
`define STAT_SRC_HI             1
`define STAT_SRC_LO             0
`define STAT_HALTED_BIT         2
`define STAT_SLEEP_BIT          3
`define STAT_CLOCK_ON_BIT       4

// system clock source codes
`define SRC_SUB                 2'h0
`define SRC_FAST                2'h1
`define SRC_DIV                 2'h2

// divider select codes below this pick the substitute clock
`define DIV_SEL_FIRST_DIVIDED   3'h2

// oscillator ticks counted before the ready flags rise after a wake-up
`define FAST_XTAL_READY_TICKS   10'h200
`define FAST_RC_READY_TICKS     10'h010
`define SLOW_XTAL_READY_TICKS   10'h080
`define SLOW_RC_READY_TICKS     10'h002

`endif

// ==== osc_ready_counter.v ====
// counts oscillator ticks after start until the oscillator is deemed stable
`timescale 1ns/10ps
`default_nettype none

module osc_ready_counter
(
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // oscillator side
  input  wire        osc_run,
  input  wire        osc_tick,
  input  wire [9:0]  ready_ticks,
  // result
  output reg         ready_reg
);

  reg  [9:0]  count_reg;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_reg <= 10'h000;
      ready_reg <= 1'b0;
    end
    else if (!osc_run)
    begin
      // a stopped oscillator must prove itself again after restart
      count_reg <= 10'h000;
      ready_reg <= 1'b0;
    end
    else if (osc_tick && !ready_reg)
    begin
      count_reg <= count_reg + 10'h001;
      ready_reg <= (count_reg + 10'h001) >= ready_ticks;
    end
  end

endmodule // osc_ready_counter

`default_nettype wire

// ==== fast_clock_divider.v ====
// prescaler giving fast clock ticks divided by 2, 4, 8, 16, 32 and 64
`timescale 1ns/10ps
`default_nettype none

module fast_clock_divider
(
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // fast clock ticks
  input  wire        fast_run,
  input  wire        fast_tick,
  // divided ticks, bit k is divide by 2**(k+1)
  output reg  [5:0]  div_tick_reg
);

  reg  [5:0]  prescale_reg;
  reg  [5:0]  div_tick_next;
  integer     k;

  always @*
  begin
    div_tick_next = 6'h00;
    for (k = 0; k < 6; k = k + 1)
      div_tick_next[k] = fast_tick & (&(prescale_reg | ~((6'h02 << k) - 6'h01)));
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prescale_reg <= 6'h00;
      div_tick_reg <= 6'h00;
    end
    else if (!fast_run)
    begin
      prescale_reg <= 6'h00;
      div_tick_reg <= 6'h00;
    end
    else
    begin
      if (fast_tick)
        prescale_reg <= prescale_reg + 6'h01;
      div_tick_reg <= div_tick_next;
    end
  end

endmodule // fast_clock_divider

`default_nettype wire

// ==== system_clock_source_select.v ====
// system clock source selection with APB register access
//
// Operation
// - system clock is fast, divided fast or substitute per mode control bits.
// - fast clock comes from fast crystal or fast RC, fixed by configuration.
// - substitute clock comes from slow crystal or slow RC by configuration.
// - divided fast clock offers ratios 2 up to 64.
// - time base clock comes from slow crystal or slow RC by configuration.
// - after wake-up substitute clock may serve as temporary system clock.
// - switching from fast to substitute clock stops the fast oscillator.
// - slow crystal runs quick-start when low-power bit is 0, low-power when 1.
// - low-power bit clears at power-on.
// - slow crystal keeps running in either low-power setting.
// - fast RC delivers 8, 12 or 16 MHz without external pins.
// - selecting fast RC frees the fast crystal pins for general I/O.
// - slow crystal pins are general I/O when slow crystal is unused.
// - slow oscillators clock the watchdog and time base logic.
// - sleep or idle0 stops system clock; independent clock keeps timers alive.
// - divider codes 000/001 pick substitute, 010..111 pick fast/64 to fast/2.
// - fast-select high picks undivided fast clock, low defers to divider.
// - fast ready after 512 crystal ticks or 16 RC ticks from wake-up.
// - slow ready after 128 crystal ticks or 2 RC ticks from wake-up.
`timescale 1ns/10ps
`default_nettype none
`include "clock_select_defines.vh"

module system_clock_source_select
(
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // configuration options
  input  wire        cfg_fast_from_rc,
  input  wire        cfg_slow_from_rc,
  input  wire [1:0]  cfg_fast_rc_freq,
  // oscillator ticks, one pclk cycle per oscillator period
  input  wire        ext_fast_crystal_osc,
  input  wire        int_fast_rc_osc,
  input  wire        ext_slow_crystal_osc,
  input  wire        int_slow_rc_osc,
  // power mode events from the core
  input  wire        halt_req,
  input  wire        wake_req,
  // oscillator control
  output reg         fast_xtal_enable,
  output reg         fast_rc_enable,
  output reg  [1:0]  fast_rc_freq_sel,
  output reg         slow_xtal_enable,
  output reg         slow_crystal_low_power,
  output reg         fast_crystal_pins_gpio,
  output reg         slow_crystal_pins_gpio,
  // clock ticks and ready flags to the rest of the chip
  output reg         fast_clock,
  output reg         substitute_clock,
  output reg         time_base_clock,
  output reg         system_clock_out,
  output reg         fast_osc_ready_flag,
  output reg         slow_osc_ready_flag
);

  //////////////////////////////////////////////////////////////////////////
  // registers and state

  reg  [7:0]  sys_mode_control_reg;
  reg  [7:0]  time_base_control_reg;
  reg  [7:0]  sys_control_reg;
  reg         halted_reg;
  reg         sleep_reg;
  reg  [1:0]  cur_src_reg;
  reg  [2:0]  cur_div_reg;
  reg  [1:0]  cur_src_next;
  reg  [2:0]  cur_div_next;

  wire [2:0]  clock_divider_select;
  wire        sys_clock_fast_select;
  wire        fast_wake_enable;
  wire        idle_enable;
  wire        system_clock_out_on;
  wire [5:0]  div_tick;
  wire        fast_ready;
  wire        slow_ready;

  assign clock_divider_select  =
    sys_mode_control_reg[`MODE_DIV_SEL_HI:`MODE_DIV_SEL_LO];
  assign sys_clock_fast_select = sys_mode_control_reg[`MODE_FAST_SELECT_BIT];
  assign fast_wake_enable      = sys_mode_control_reg[`MODE_FAST_WAKE_BIT];
  assign idle_enable           = sys_mode_control_reg[`MODE_IDLE_ENABLE_BIT];
  assign system_clock_out_on               = sys_control_reg[`SYS_SYSTEM_CLOCK_OUT_ON_BIT];

  //////////////////////////////////////////////////////////////////////////
  // oscillator source picks

  wire        fast_tick_raw;
  wire        slow_tick;
  wire [9:0]  fast_ready_ticks;
  wire [9:0]  slow_ready_ticks;

  assign fast_tick_raw = cfg_fast_from_rc ? int_fast_rc_osc
                                          : ext_fast_crystal_osc;
  assign slow_tick     = cfg_slow_from_rc ? int_slow_rc_osc
                                          : ext_slow_crystal_osc;
  assign fast_ready_ticks = cfg_fast_from_rc ? `FAST_RC_READY_TICKS
                                             : `FAST_XTAL_READY_TICKS;
  assign slow_ready_ticks = cfg_slow_from_rc ? `SLOW_RC_READY_TICKS
                                             : `SLOW_XTAL_READY_TICKS;

  //////////////////////////////////////////////////////////////////////////
  // target source and fast oscillator run request

  reg  [1:0]  target_src;
  reg         target_ready;
  reg         fast_run;
  wire        clock_on;
  wire        fast_tick;

  always @*
  begin
    if (sys_clock_fast_select)
      target_src = `SRC_FAST;
    else if (clock_divider_select < `DIV_SEL_FIRST_DIVIDED)
      target_src = `SRC_SUB;
    else
      target_src = `SRC_DIV;
    target_ready = (target_src == `SRC_SUB) ? slow_ready : fast_ready;
  end

  // the fast oscillator only stops once the substitute clock has taken over,
  // and in sleep or idle0 where nothing needs it
  always @*
  begin
    fast_run = 1'b1;
    if (cur_src_reg == `SRC_SUB && target_src == `SRC_SUB)
      fast_run = 1'b0;
    if (halted_reg && (sleep_reg || !system_clock_out_on))
      fast_run = 1'b0;
  end

  assign fast_tick = fast_tick_raw & fast_run;
  // idle1 keeps the system clock running for peripherals
  assign clock_on  = !halted_reg || (!sleep_reg && system_clock_out_on);

  osc_ready_counter fast_ready_counter
  (
    .pclk        (pclk),
    .presetn     (presetn),
    .osc_run     (fast_run),
    .osc_tick    (fast_tick),
    .ready_ticks (fast_ready_ticks),
    .ready_reg   (fast_ready)                                      
  );

  // slow side restarts its count on every wake-up
  osc_ready_counter slow_ready_counter
  (
    .pclk        (pclk),
    .presetn     (presetn),
    .osc_run     (!wake_req),
    .osc_tick    (slow_tick),
    .ready_ticks (slow_ready_ticks),
    .ready_reg   (slow_ready)
  );

  fast_clock_divider prescaler
  (
    .pclk         (pclk),
    .presetn      (presetn),
    .fast_run     (fast_run),
    .fast_tick    (fast_tick),
    .div_tick_reg (div_tick)                                       
  );

  //////////////////////////////////////////////////////////////////////////
  // source switching

  reg         cur_ready;
  reg         cur_tick;
  reg         new_tick;
  reg  [1:0]  want_src;

  // divided code 010 maps to /64 (div_tick[5]) down to 111 for /2
  function sel_div_tick;
    input [2:0] code;
    input [5:0] ticks;
    begin
      sel_div_tick = ticks[3'h7 - code];
    end
  endfunction

  always @*
  begin
    cur_ready = (cur_src_reg == `SRC_SUB) ? slow_ready : fast_ready;
    case (cur_src_reg)
      `SRC_SUB:  cur_tick = slow_tick;
      `SRC_FAST: cur_tick = fast_tick;
      `SRC_DIV:  cur_tick = sel_div_tick(cur_div_reg, div_tick);
      default:   cur_tick = 1'b0;
    endcase
    // without a ready target, wake-up may borrow the substitute clock
    if (target_ready)
      want_src = target_src;
    else if (fast_wake_enable && slow_ready)
      want_src = `SRC_SUB;
    else
      want_src = cur_src_reg;
    case (want_src)
      `SRC_SUB:  new_tick = slow_tick;
      `SRC_FAST: new_tick = fast_tick;
      `SRC_DIV:  new_tick = sel_div_tick(clock_divider_select, div_tick);
      default:   new_tick = 1'b0;
    endcase
  end

  // change only on a tick of the new source, so the first output pulse
  // after a switch is never a cut-short period of either source
  always @*
  begin
    cur_src_next = cur_src_reg;
    cur_div_next = cur_div_reg;
    if ((want_src != cur_src_reg ||
         (want_src == `SRC_DIV && clock_divider_select != cur_div_reg))
        && new_tick)
    begin
      cur_src_next = want_src;
      cur_div_next = clock_divider_select;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // halt and wake tracking

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      halted_reg <= 1'b0;
      sleep_reg  <= 1'b0;
    end
    else if (halt_req && !halted_reg)
    begin
      halted_reg <= 1'b1;
      sleep_reg  <= !idle_enable;
    end
    else if (wake_req)
    begin
      halted_reg <= 1'b0;
      sleep_reg  <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // clock outputs

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_src_reg          <= `SRC_FAST;
      cur_div_reg          <= 3'h0;
      fast_clock           <= 1'b0;
      substitute_clock     <= 1'b0;
      time_base_clock      <= 1'b0;
      system_clock_out     <= 1'b0;
      fast_osc_ready_flag  <= 1'b0;
      slow_osc_ready_flag  <= 1'b0;
    end
    else
    begin
      cur_src_reg          <= cur_src_next;
      cur_div_reg          <= cur_div_next;
      fast_clock           <= fast_tick;
      // the slow ticks stay independent of halt for watchdog and time base
      substitute_clock     <= slow_tick;
      time_base_clock      <= slow_tick;
      system_clock_out     <= cur_tick & cur_ready & clock_on;
      fast_osc_ready_flag  <= fast_ready;
      slow_osc_ready_flag  <= slow_ready;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // oscillator and pin control

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fast_xtal_enable       <= 1'b0;
      fast_rc_enable         <= 1'b0;
      fast_rc_freq_sel       <= 2'h0;
      slow_xtal_enable       <= 1'b0;
      slow_crystal_low_power <= 1'b0;
      fast_crystal_pins_gpio <= 1'b0;
      slow_crystal_pins_gpio <= 1'b0;
    end
    else
    begin
      fast_xtal_enable       <= fast_run & !cfg_fast_from_rc;
      fast_rc_enable         <= fast_run & cfg_fast_from_rc;
      fast_rc_freq_sel       <= cfg_fast_rc_freq;
      // low power only trims start-up current, never stops the crystal
      slow_xtal_enable       <= !cfg_slow_from_rc;
      slow_crystal_low_power <=
        time_base_control_reg[`TBC_SLOW_LOW_POWER_BIT];
      fast_crystal_pins_gpio <= cfg_fast_from_rc;
      slow_crystal_pins_gpio <= cfg_slow_from_rc;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state so read data comes from a flip-flop

  wire        access;
  wire        commit;
  wire        addr_hit;
  reg  [31:0] read_word;

  assign access   = psel & penable;
  assign commit   = access & pready;
  assign addr_hit = (paddr == `MODE_CTRL_OFFSET) ||
                    (paddr == `TIME_BASE_CTRL_OFFSET) ||
                    (paddr == `SYS_CTRL_OFFSET) ||
                    (paddr == `CLOCK_STATUS_OFFSET);

  always @*
  begin
    read_word = 32'h0000_0000;
    case (paddr)
      `MODE_CTRL_OFFSET:
      begin
        read_word[7:0] = sys_mode_control_reg;
        read_word[`MODE_SLOW_READY_BIT] = slow_ready;
        read_word[`MODE_FAST_READY_BIT] = fast_ready;
      end
      `TIME_BASE_CTRL_OFFSET: read_word[7:0] = time_base_control_reg;
      `SYS_CTRL_OFFSET:       read_word[7:0] = sys_control_reg;
      `CLOCK_STATUS_OFFSET:
      begin
        read_word[`STAT_SRC_HI:`STAT_SRC_LO] = cur_src_reg;
        read_word[`STAT_HALTED_BIT]          = halted_reg;
        read_word[`STAT_SLEEP_BIT]           = sleep_reg;
        read_word[`STAT_CLOCK_ON_BIT]        = clock_on;
      end
      default: read_word = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= access & !pready;
      pslverr <= access & !pready & !addr_hit;
      prdata  <= (access & !pready & !pwrite) ? read_word : 32'h0000_0000;
    end
  end

  // power-on clears the low-power bit so the crystal starts quickly
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_mode_control_reg  <= `MODE_CTRL_RESET;
      time_base_control_reg <= `TBC_RESET;
      sys_control_reg       <= `SYS_CTRL_RESET;
    end
    else if (commit && pwrite && pstrb[0])
    begin
      case (paddr)
        `MODE_CTRL_OFFSET:
        begin
          // ready flags are read-only, kept at zero in storage
          sys_mode_control_reg <= pwdata[7:0] &
            ~((8'h01 << `MODE_SLOW_READY_BIT) |
              (8'h01 << `MODE_FAST_READY_BIT));
        end
        `TIME_BASE_CTRL_OFFSET:
          time_base_control_reg <= pwdata[7:0];
        `SYS_CTRL_OFFSET:
          sys_control_reg <= pwdata[7:0];
        default:
          sys_control_reg <= sys_control_reg;
      endcase
    end
  end

endmodule // system_clock_source_select

`default_nettype wire

// ==== cs_asserts.sv ====
// port-level assertions of the clock source selector
`timescale 1ns/10ps
`default_nettype none
`include "clock_select_defines.vh"
module cs_asserts
(
  // clock, reset and bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  // configuration and ticks
  input wire logic        cfg_fast_from_rc,
  input wire logic        cfg_slow_from_rc,
  input wire logic [1:0]  cfg_fast_rc_freq,
  input wire logic        ext_fast_crystal_osc,
  input wire logic        int_fast_rc_osc,
  input wire logic        ext_slow_crystal_osc,
  input wire logic        int_slow_rc_osc,
  // outputs watched
  input wire logic        fast_xtal_enable,
  input wire logic        fast_rc_enable,
  input wire logic [1:0]  fast_rc_freq_sel,
  input wire logic        slow_xtal_enable,
  input wire logic        slow_crystal_low_power,
  input wire logic        fast_crystal_pins_gpio,
  input wire logic        slow_crystal_pins_gpio,
  input wire logic        fast_clock,
  input wire logic        substitute_clock,
  input wire logic        time_base_clock
);
  wire tbc_wr = psel && penable && pready && pwrite && pstrb[0]
    && paddr == `TIME_BASE_CTRL_OFFSET;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // no attempt starts on the edges that release reset: outputs still reset
  property p_fpins; $past(presetn) && $stable(cfg_fast_from_rc) |=>
    fast_crystal_pins_gpio == $past(cfg_fast_from_rc); endproperty
  a_fpins: assert property (p_fpins)
    else $error("fast crystal pins off config");
  property p_spins; $past(presetn) && $stable(cfg_slow_from_rc) |=>
    slow_crystal_pins_gpio == $past(cfg_slow_from_rc); endproperty
  a_spins: assert property (p_spins)
    else $error("slow crystal pins off config");
  property p_sen; $past(presetn) && $stable(cfg_slow_from_rc) |=>
    slow_xtal_enable != $past(cfg_slow_from_rc); endproperty
  a_sen: assert property (p_sen)
    else $error("slow crystal run request wrong");
  property p_freq; $past(presetn) && $stable(cfg_fast_rc_freq) |=>
    fast_rc_freq_sel == $past(cfg_fast_rc_freq); endproperty
  a_freq: assert property (p_freq)
    else $error("rc frequency select wrong");
  property p_lp; $changed(slow_crystal_low_power) |->
    $past(tbc_wr) || $past(tbc_wr, 2); endproperty
  a_lp: assert property (p_lp)
    else $error("low power bit moved without write");
  property p_fclk; fast_clock |-> $past(cfg_fast_from_rc ?
    int_fast_rc_osc : ext_fast_crystal_osc); endproperty
  a_fclk: assert property (p_fclk)
    else $error("fast clock tick from wrong source");
  property p_sub; substitute_clock |-> $past(cfg_slow_from_rc ?
    int_slow_rc_osc : ext_slow_crystal_osc); endproperty
  a_sub: assert property (p_sub)
    else $error("substitute tick from wrong source");
  property p_tb; time_base_clock |-> $past(cfg_slow_from_rc ?
    int_slow_rc_osc : ext_slow_crystal_osc); endproperty
  a_tb: assert property (p_tb)
    else $error("time base tick from wrong source");
  property p_excl; !(fast_xtal_enable && fast_rc_enable); endproperty
  a_excl: assert property (p_excl)
    else $error("both fast oscillators requested");
endmodule // cs_asserts
bind system_clock_source_select cs_asserts chk
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pstrb, .pready,
  .cfg_fast_from_rc, .cfg_slow_from_rc, .cfg_fast_rc_freq,
  .ext_fast_crystal_osc, .int_fast_rc_osc, .ext_slow_crystal_osc,
  .int_slow_rc_osc, .fast_xtal_enable, .fast_rc_enable, .fast_rc_freq_sel,
  .slow_xtal_enable, .slow_crystal_low_power, .fast_crystal_pins_gpio,
  .slow_crystal_pins_gpio, .fast_clock, .substitute_clock, .time_base_clock
);
`default_nettype wire

// ==== osc_model.sv ====
// oscillator model: free-running ticks that stop when not requested
`timescale 1ns/10ps
`default_nettype none
module osc_model
#(
  parameter int FP = 2,
  parameter int SP = 6
)
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // run requests
  input  wire logic fast_xtal_enable,
  input  wire logic fast_rc_enable,
  input  wire logic slow_xtal_enable,
  // ticks
  output logic      ext_fast_crystal_osc,
  output logic      int_fast_rc_osc,
  output logic      ext_slow_crystal_osc,
  output logic      int_slow_rc_osc
);
  int fc;
  int sc;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      fc <= 0;
      sc <= 0;
    end
    else
    begin
      fc <= (fc + 1) % FP;
      sc <= (sc + 1) % SP;
    end
  // a stopped oscillator gives no ticks, so no stale phase leaks through
  assign ext_fast_crystal_osc = fast_xtal_enable && fc == 0;
  assign int_fast_rc_osc      = fast_rc_enable && fc == 0;
  // low-power setting never stops the crystal
  assign ext_slow_crystal_osc = slow_xtal_enable && sc == 0;
  assign int_slow_rc_osc      = sc == 0;
endmodule // osc_model
`default_nettype wire

// ==== test_system_clock_source_select.sv ====
// self-checking testbench of the clock source selector
`timescale 1ns/10ps
`default_nettype none
module test_system_clock_source_select;
  localparam int FP = 2;
  localparam int SP = 6;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, p;
  logic [3:0]  pstrb;
  logic        cfg_fast_from_rc, cfg_slow_from_rc, halt_req, wake_req;
  logic [1:0]  cfg_fast_rc_freq, fast_rc_freq_sel;
  logic        ext_fast_crystal_osc, int_fast_rc_osc;
  logic        ext_slow_crystal_osc, int_slow_rc_osc;
  logic        fast_xtal_enable, fast_rc_enable, slow_xtal_enable;
  logic        slow_crystal_low_power, fast_crystal_pins_gpio;
  logic        slow_crystal_pins_gpio, fast_clock, substitute_clock;
  logic        time_base_clock, system_clock_out;
  logic        fast_osc_ready_flag, slow_osc_ready_flag;
  int          bad_count, n_checks, nf, ns;
  system_clock_source_select uut
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .cfg_fast_from_rc, .cfg_slow_from_rc,
    .cfg_fast_rc_freq, .ext_fast_crystal_osc, .int_fast_rc_osc,
    .ext_slow_crystal_osc, .int_slow_rc_osc, .halt_req, .wake_req,
    .fast_xtal_enable, .fast_rc_enable, .fast_rc_freq_sel,
    .slow_xtal_enable, .slow_crystal_low_power, .fast_crystal_pins_gpio,
    .slow_crystal_pins_gpio, .fast_clock, .substitute_clock,
    .time_base_clock, .system_clock_out, .fast_osc_ready_flag,
    .slow_osc_ready_flag
  );
  osc_model #(.FP(FP), .SP(SP)) osc
  (
    .pclk, .presetn, .fast_xtal_enable, .fast_rc_enable, .slow_xtal_enable,
    .ext_fast_crystal_osc, .int_fast_rc_osc, .ext_slow_crystal_osc,
    .int_slow_rc_osc
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // codes 0 and 1 give the substitute clock, the rest fast/64 .. fast/2
  function automatic logic [31:0] exp_per(input logic [2:0] c);
    return (c < 3'h2) ? SP : FP << (8 - c);
  endfunction
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    check(n < 20, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic edge_wait(output logic [31:0] c);
    c = 0;
    do
    begin
      @(posedge pclk);
      c++;
    end
    while (system_clock_out !== 1'b1 && c < 4000);
  endtask
  // the last of several intervals, so a pending switch has settled
  task automatic period(output logic [31:0] c);
    repeat (5) edge_wait(c);
  endtask
  task automatic pulse(input logic h);
    @(posedge pclk);
    halt_req <= h;
    wake_req <= !h;
    @(posedge pclk);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial
  begin
    #4_000_000;
    bad_count++;
    final_report();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, halt_req, wake_req} = '0;
    {cfg_fast_from_rc, cfg_slow_from_rc, cfg_fast_rc_freq} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    bad_count = 0;
    n_checks = 0;
    seed = 32'h0000_0005;
    for (int cf = 0; cf < 2; cf++)
    begin
      seed = xs(seed);
      @(posedge pclk);
      presetn <= 1'b0;
      {cfg_fast_from_rc, cfg_slow_from_rc} <= {2{cf[0]}};
      cfg_fast_rc_freq <= seed[1:0];
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      nf = 0;
      ns = 0;
      for (int i = 1; i < 3000 && !(nf && ns); i++)
      begin
        @(posedge pclk);
        if (!nf && fast_osc_ready_flag === 1'b1) nf = i;
        if (!ns && slow_osc_ready_flag === 1'b1) ns = i;
      end
      check(nf inside {[(cf?15:511)*FP:(cf?17:513)*FP+4]}, 1);
      check(ns inside {[(cf?1:127)*SP:(cf?3:129)*SP+4]}, 1);
      apb(0, 12'h000, 0);
      check(rd & 32'h0000_00f3, 32'h0000_0003);
      apb(0, 12'h004, 0);
      check(rd, 0);
      apb(0, 12'h010, 0);
      check({rd[30:0], err}, 1);
      check(fast_crystal_pins_gpio, cf[0]);
      check(slow_crystal_pins_gpio, cf[0]);
      check({fast_xtal_enable, fast_rc_enable}, {!cf[0], cf[0]});
      check(fast_rc_freq_sel, seed[1:0]);
      period(p);
      check(p, FP);
      for (int c = 7; c >= 0; c--)
      begin
        apb(1, 12'h000, {24'h0, c[2:0], 5'h02});
        period(p);
        check(p, exp_per(c[2:0]));
      end
      check({fast_xtal_enable, fast_rc_enable}, 0);
      repeat (4)
      begin
        seed = xs(seed);
        apb(1, 12'h004, seed);
        apb(0, 12'h004, 0);
        check(rd[0], seed[0]);
        check(slow_crystal_low_power, seed[0]);
        period(p);
        check(p, SP);
      end
      apb(1, 12'h000, 32'h0000_0001);
      for (int i = 0; i < 4000 && fast_osc_ready_flag !== 1'b1; i++)
        @(posedge pclk);
      period(p);
      check(p, FP);
      pulse(1'b1);
      repeat (5) @(posedge pclk);
      nf = 0;
      repeat (200)
      begin
        @(posedge pclk);
        nf += system_clock_out;
      end
      check(nf, 0);
      check(fast_osc_ready_flag, 0);
      apb(0, 12'h00c, 0);
      check(rd[3:2], 2'b11);
      pulse(1'b0);
      edge_wait(p);
      check(p >= (cf ? 15 : 511) * FP && p < 4000, 1);
      // idle with the system clock kept on for peripherals
      apb(1, 12'h008, 1);
      apb(1, 12'h000, 32'h0000_0003);
      pulse(1'b1);
      period(p);
      check(p, FP);
      pulse(1'b0);
      apb(1, 12'h008, 0);
      apb(1, 12'h000, 32'h0000_0013);
      pulse(1'b1);
      repeat (20) @(posedge pclk);
      pulse(1'b0);
      edge_wait(p);
      check(p < 4000, 1);
      if (cf == 0) check(fast_osc_ready_flag, 0);
    end
    final_report();
  end
endmodule // test_system_clock_source_select
`default_nettype wire
